// >>> hw/sdrpin_consts.svh
`ifndef SDRPIN_CONSTS_SVH
`define SDRPIN_CONSTS_SVH

// Address and bank pin fields
`define SDRPIN_AP_BIT        10
`define SDRPIN_EMR_DQSN_DIS  10
`define SDRPIN_EMR_READ_ONLY_STROBE_EN   11
`define SDRPIN_EMR_RTT_A     2
`define SDRPIN_EMR_RTT_B     6
`define SDRPIN_BL8_CODE      3'h3
`define SDRPIN_MR_RST        14'h0002
`define SDRPIN_EMR_RST       14'h0000
`define SDRPIN_BA_MR         3'h0
`define SDRPIN_BA_EMR1       3'h1

// Controller register offsets and burst beat count
`define SDRPIN_REG_CTRL      8'h00
`define SDRPIN_REG_CMD       8'h04
`define SDRPIN_REG_ADDR      8'h08
`define SDRPIN_REG_WDLO      8'h0c
`define SDRPIN_REG_WDHI      8'h10
`define SDRPIN_REG_WMASK     8'h14
`define SDRPIN_REG_STATUS    8'h18
`define SDRPIN_REG_RDLO      8'h1c
`define SDRPIN_REG_RDHI      8'h20
`define SDRPIN_CTL_BEATS     4

`endif

// >>> hw/sdrpin_pkg.sv
package sdrpin_pkg;
    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR  = 3'b100,
        CMD_RD  = 3'b101,
        CMD_BST = 3'b110,
        CMD_NOP = 3'b111
    } sdrpin_cmd_t;

    typedef enum logic [1:0] {
        DEV_IDLE  = 2'b00,
        DEV_WRITE = 2'b01,
        DEV_READ  = 2'b10
    } sdrpin_dev_state_t;

    typedef enum logic [2:0] {
        CTL_IDLE    = 3'b000,
        CTL_CMD_LO  = 3'b001,
        CTL_CMD_HI  = 3'b010,
        CTL_WR_SET  = 3'b011,
        CTL_WR_STB  = 3'b100,
        CTL_WR_POST = 3'b101,
        CTL_RD_WAIT = 3'b110
    } sdrpin_ctl_state_t;
endpackage : sdrpin_pkg

// >>> hw/sdrpin_if.sv
interface sdrpin_if #(
    parameter int DQ_W = 16
);
    localparam int LANES = DQ_W / 8;

    logic             ck;
    logic             cke;
    logic             csN;
    logic             rasN;
    logic             casN;
    logic             weN;
    logic [2:0]       ba;
    logic [13:0]      addr;
    logic             termination_enable_pin;
    logic [DQ_W-1:0]  ctlDq;
    logic             ctlDqOeN;
    logic [LANES-1:0] ctlDqs;
    logic             ctlDqsOeN;
    logic [LANES-1:0] ctlDm;
    logic [DQ_W-1:0]  devDq;
    logic             devDqOeN;
    logic [LANES-1:0] devDqs;
    logic             devDqsOeN;
    logic [LANES-1:0] devDqsN;
    logic             devDqsNOeN;
    logic             devRdqs;
    logic             devRdqsOeN;
    logic [DQ_W-1:0]  dq;
    logic [LANES-1:0] dqs;
    logic [LANES-1:0] dqsN;
    logic [LANES-1:0] dm;

    // Undriven dq and dqs settle low; dqsN then sits high as ~dqs
    assign dq   = !devDqOeN ? devDq : (!ctlDqOeN ? ctlDq : '0);
    assign dqs  = !devDqsOeN ? devDqs : (!ctlDqsOeN ? ctlDqs : '0);
    assign dqsN = !devDqsNOeN ? devDqsN : ~dqs;
    assign dm   = devRdqsOeN ? ctlDm : ((ctlDm & ~LANES'(1)) | LANES'(devRdqs));

    modport ctl (
        output ck, cke, csN, rasN, casN, weN, ba, addr, termination_enable_pin,
        output ctlDq, ctlDqOeN, ctlDqs, ctlDqsOeN, ctlDm,
        input  dq, dqs
    );
    modport dev (
        input  ck, cke, csN, rasN, casN, weN, ba, addr, termination_enable_pin, dq, dqs, dm,
        output devDq, devDqOeN, devDqs, devDqsOeN, devDqsN, devDqsNOeN,
        output devRdqs, devRdqsOeN
    );
endinterface : sdrpin_if

// >>> hw/sdrpin_device.sv
// Notes on behaviour
// R1 - Sample command and address on clock rise
// R2 - Clock enable low gates clock, powers down
// R3 - Chip select high ignores new commands
// R4 - RAS CAS WE levels select the command
// R5 - Activate row from A0-A13 or A0-A12
// R6 - Column address is ten bits, CA9 top
// R7 - A10 on access selects auto precharge
// R8 - Precharge with A10 closes all banks
// R9 - Bank pins select the addressed bank
// R10 - Data bus eight or sixteen bits, bidirectional
// R11 - Read strobe edge aligned, write strobe centred
// R12 - Each byte lane has its own strobe
// R13 - Mode bit turns mask into read strobe; the device does this only when DQ_W is 8, and ignores the bit at 16
// R14 - One mode bit enables complementary strobes
// R15 - Masked write beats are discarded
// R16 - Each byte lane has its own mask
// R17 - Termination pin honoured only when enabled
// R18 - Mode write: all low with bank bits
// R19 - Mode bits 10 and 11 set strobes
// R20 - Controller deselects when not commanding
`include "sdrpin_consts.svh"
module sdrpin_device #(
    parameter int DQ_W     = 16,
    parameter int ROW_BITS = 2,
    parameter int COL_BITS = 4
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    sdrpin_if.dev           pins,
    output logic [7:0]      bankOpen,
    output logic            powerDown,
    output logic            termActive,
    output logic            busy
);
    localparam int LANES = DQ_W / 8;
    localparam int IDX_W = 3 + ROW_BITS + COL_BITS;
    localparam int DEPTH = 1 << IDX_W;
    localparam int IN_W  = 24 + DQ_W + 2 * LANES;

    if (DQ_W != 8 && DQ_W != 16) begin : g_badWidth
        $error("sdrpin_device: DQ_W must be 8 or 16");
    end
    if (COL_BITS < 3 || COL_BITS > 10 || ROW_BITS < 1 || ROW_BITS > 13) begin : g_badDepth
        $error("sdrpin_device: COL_BITS 3..10 and ROW_BITS 1..13");
    end

    function automatic sdrpin_pkg::sdrpin_cmd_t decodeCmd(input logic [2:0] rcw);
        decodeCmd = sdrpin_pkg::sdrpin_cmd_t'(rcw);
    endfunction : decodeCmd

    // Every pin crosses into core_clk through two flops
    logic [IN_W-1:0]  syncA_r;
    logic [IN_W-1:0]  syncB_r;
    logic             ckS;
    logic             ckeS;
    logic             csNS;
    logic [2:0]       rcwS;
    logic [2:0]       baS;
    logic [13:0]      addrS;
    logic             odtS;
    logic [DQ_W-1:0]  dqS;
    logic [LANES-1:0] dqsS;
    logic [LANES-1:0] dmS;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {pins.ck, pins.cke, pins.csN, pins.rasN, pins.casN, pins.weN,
                        pins.ba, pins.addr, pins.termination_enable_pin, pins.dq, pins.dqs, pins.dm};
            syncB_r <= syncA_r;
        end
    end
    assign {ckS, ckeS, csNS, rcwS, baS, addrS, odtS, dqS, dqsS, dmS} = syncB_r;

    sdrpin_pkg::sdrpin_dev_state_t state_r;
    logic                          ckPrev_r;
    logic [LANES-1:0]              dqsPrev_r;
    logic [13:0]                   modeReg_r;
    logic [13:0]                   emr1_r;
    logic [13:0]                   rowAddr_r [8];
    logic [2:0]                    bank_r;
    logic [9:0]                    col_r;
    logic                          autoPre_r;
    logic [3:0]                    beat_r;
    logic                          dqsOut_r;
    logic                          oeN_r;
    logic [LANES-1:0]              wrDone;
    logic [DQ_W-1:0]               rdData;

    logic                    ckRise;
    logic                    cmdLive;
    sdrpin_pkg::sdrpin_cmd_t cmd;
    logic                    x16;
    logic [13:0]             rowIn;
    logic [9:0]              colIn;
    logic [3:0]              burstLen;
    logic                    rdqsOn;
    logic                    dqsNOn;
    logic                    rttOn;
    logic [LANES-1:0]        dqsEdge;
    logic                    accessOk;
    logic                    wrEnd;
    logic                    rdEnd;
    logic [ROW_BITS-1:0]     rowLo;

    assign ckRise   = ckS & ~ckPrev_r;                          // R1
    assign cmdLive  = ckRise & ckeS & ~csNS;                    // R2 R3
    assign cmd      = decodeCmd(rcwS);                          // R4
    assign x16      = (DQ_W == 16);
    assign rowIn    = x16 ? {1'b0, addrS[12:0]} : addrS;        // R5
    assign colIn    = addrS[9:0];                               // R6
    assign burstLen = (modeReg_r[2:0] == `SDRPIN_BL8_CODE) ? 4'h8 : 4'h4;
    assign rdqsOn   = !x16 && emr1_r[`SDRPIN_EMR_READ_ONLY_STROBE_EN];      // R13 R19
    assign dqsNOn   = ~emr1_r[`SDRPIN_EMR_DQSN_DIS];            // R14 R19
    assign rttOn    = emr1_r[`SDRPIN_EMR_RTT_A] | emr1_r[`SDRPIN_EMR_RTT_B];
    assign dqsEdge  = dqsS ^ dqsPrev_r;
    assign accessOk = (state_r == sdrpin_pkg::DEV_IDLE) && bankOpen[baS];
    assign wrEnd    = (state_r == sdrpin_pkg::DEV_WRITE) && (&wrDone);
    assign rdEnd    = (state_r == sdrpin_pkg::DEV_READ) && (beat_r == burstLen);
    assign rowLo    = rowAddr_r[bank_r][ROW_BITS-1:0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r    <= sdrpin_pkg::DEV_IDLE;
            ckPrev_r   <= 1'b0;
            dqsPrev_r  <= '0;
            modeReg_r  <= `SDRPIN_MR_RST;
            emr1_r     <= `SDRPIN_EMR_RST;
            bank_r     <= 3'h0;
            col_r      <= 10'h000;
            autoPre_r  <= 1'b0;
            beat_r     <= 4'h0;
            bankOpen   <= 8'h00;
            powerDown  <= 1'b0;
            termActive <= 1'b0;
            busy       <= 1'b0;
            for (int b = 0; b < 8; b++) begin
                rowAddr_r[b] <= 14'h0000;
            end
        end else begin
            ckPrev_r   <= ckS;
            dqsPrev_r  <= dqsS;
            termActive <= odtS & rttOn;                         // R17
            if (ckRise) begin
                powerDown <= ~ckeS;                             // R2
            end
            // Burst end first, so an ACT or PRE in the same cycle overrides its auto precharge; a new access then is refused
            if (wrEnd || rdEnd) begin
                state_r <= sdrpin_pkg::DEV_IDLE;
                busy    <= 1'b0;
                if (autoPre_r) begin
                    bankOpen[bank_r] <= 1'b0;                   // R7
                end
            end
            if (state_r == sdrpin_pkg::DEV_READ && !rdEnd) begin
                beat_r <= beat_r + 4'h1;
            end
            if (cmdLive) begin
                case (cmd)
                    sdrpin_pkg::CMD_MRS: begin
                        if (baS == `SDRPIN_BA_MR) begin             // R18
                            modeReg_r <= addrS;
                        end else if (baS == `SDRPIN_BA_EMR1) begin
                            emr1_r <= addrS;                        // R19
                        end
                    end
                    sdrpin_pkg::CMD_ACT: begin
                        bankOpen[baS]  <= 1'b1;                     // R9
                        rowAddr_r[baS] <= rowIn;                    // R5
                    end
                    sdrpin_pkg::CMD_PRE: begin
                        if (addrS[`SDRPIN_AP_BIT]) begin
                            bankOpen <= 8'h00;                      // R8
                        end else begin
                            bankOpen[baS] <= 1'b0;                  // R8
                        end
                    end
                    sdrpin_pkg::CMD_WR, sdrpin_pkg::CMD_RD: begin
                        // A closed bank or a burst in flight makes the access a no-op
                        if (accessOk) begin
                            bank_r    <= baS;                       // R9
                            col_r     <= colIn;                     // R6
                            autoPre_r <= addrS[`SDRPIN_AP_BIT];     // R7
                            beat_r    <= 4'h0;
                            busy      <= 1'b1;
                            state_r   <= (cmd == sdrpin_pkg::CMD_WR) ?
                                         sdrpin_pkg::DEV_WRITE : sdrpin_pkg::DEV_READ;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read strobe: one low preamble cycle, then one edge per beat with the data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dqsOut_r <= 1'b0;
            oeN_r    <= 1'b1;
        end else if (cmdLive && accessOk && cmd == sdrpin_pkg::CMD_RD) begin
            dqsOut_r <= 1'b0;
            oeN_r    <= 1'b0;                                       // R10
        end else if (state_r == sdrpin_pkg::DEV_READ && !rdEnd) begin
            dqsOut_r <= ~beat_r[0];                                 // R11
        end else begin
            dqsOut_r <= 1'b0;
            oeN_r    <= 1'b1;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [7:0]       memLane [DEPTH];
        logic [3:0]       wrCnt_r;
        logic [7:0]       rdByte_r;
        logic             laneEdge;
        logic             keep;
        logic [IDX_W-1:0] wrIdx;
        logic [IDX_W-1:0] rdIdx;

        assign laneEdge = dqsEdge[l] && (state_r == sdrpin_pkg::DEV_WRITE) &&
                          (wrCnt_r < burstLen);                     // R12
        assign keep     = ~(dmS[l] & ~rdqsOn);                      // R13 R15 R16
        assign wrIdx    = {bank_r, rowLo, col_r[COL_BITS-1:0] + wrCnt_r[COL_BITS-1:0]};
        assign rdIdx    = {bank_r, rowLo, col_r[COL_BITS-1:0] + beat_r[COL_BITS-1:0]};
        assign wrDone[l] = (wrCnt_r == burstLen);

        always_ff @(posedge core_clk) begin
            if (rst || state_r != sdrpin_pkg::DEV_WRITE) begin
                wrCnt_r <= 4'h0;
            end else if (laneEdge) begin
                wrCnt_r <= wrCnt_r + 4'h1;
            end
        end
        // Storage has no reset; contents are undefined until written
        always_ff @(posedge core_clk) begin
            if (laneEdge && keep) begin
                memLane[wrIdx] <= dqS[l*8 +: 8];                    // R11 R15
            end
            rdByte_r <= memLane[rdIdx];
        end
        assign rdData[l*8 +: 8] = rdByte_r;
    end

    assign pins.devDq      = rdData;                                // R10
    assign pins.devDqOeN   = oeN_r;
    assign pins.devDqs     = {LANES{dqsOut_r}};                     // R12
    assign pins.devDqsOeN  = oeN_r;
    assign pins.devDqsN    = {LANES{~dqsOut_r}};
    assign pins.devDqsNOeN = oeN_r | ~dqsNOn;                       // R14
    assign pins.devRdqs    = dqsOut_r;
    assign pins.devRdqsOeN = oeN_r | ~rdqsOn;                       // R13
endmodule : sdrpin_device

// >>> hw/sdrpin_ctrl.sv
`include "sdrpin_consts.svh"
module sdrpin_ctrl #(
    parameter int DQ_W = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    sdrpin_if.ctl            pins,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int LANES = DQ_W / 8;
    localparam int BEATS = `SDRPIN_CTL_BEATS;

    if (DQ_W != 8 && DQ_W != 16) begin : g_badWidth
        $error("sdrpin_ctrl: DQ_W must be 8 or 16");
    end

    sdrpin_pkg::sdrpin_ctl_state_t state_r;
    logic [1:0]              ctrl_r;
    logic [5:0]              cmdReg_r;
    logic [13:0]             addr_r;
    logic [63:0]             wdata_r;
    logic [7:0]              wmask_r;
    logic [63:0]             rdata_r;
    logic                    rdDone_r;
    logic                    launch_r;
    logic [1:0]              beat_r;
    logic                    ck_r;
    logic                    dqs_r;
    logic [DQ_W+LANES-1:0]   syncA_r;
    logic [DQ_W+LANES-1:0]   syncB_r;
    logic                    dqsPrev_r;

    logic        access;
    logic        wrTake;
    logic        hitCmd;
    logic        mapped;
    logic [31:0] rdMux;
    logic        dqsEdge;
    logic        rdSet;
    logic        busy;

    assign access  = psel & penable;
    assign wrTake  = access & pready & pwrite;
    assign hitCmd  = (paddr == `SDRPIN_REG_CMD);
    assign busy    = launch_r | (state_r != sdrpin_pkg::CTL_IDLE);
    assign dqsEdge = syncB_r[0] ^ dqsPrev_r;
    assign rdSet   = (state_r == sdrpin_pkg::CTL_RD_WAIT) && dqsEdge && (beat_r == 2'(BEATS - 1));
    assign mapped  = (paddr <= `SDRPIN_REG_RDHI) && (paddr[1:0] == 2'h0);
    assign rdMux   = (paddr == `SDRPIN_REG_CTRL)   ? {30'h0, ctrl_r} :
                     (paddr == `SDRPIN_REG_CMD)    ? {26'h0, cmdReg_r} :
                     (paddr == `SDRPIN_REG_ADDR)   ? {18'h0, addr_r} :
                     (paddr == `SDRPIN_REG_WDLO)   ? wdata_r[31:0] :
                     (paddr == `SDRPIN_REG_WDHI)   ? wdata_r[63:32] :
                     (paddr == `SDRPIN_REG_WMASK)  ? {24'h0, wmask_r} :
                     (paddr == `SDRPIN_REG_STATUS) ? {30'h0, rdDone_r, busy} :
                     (paddr == `SDRPIN_REG_RDLO)   ? rdata_r[31:0] :
                     (paddr == `SDRPIN_REG_RDHI)   ? rdata_r[63:32] : 32'h0;

    // One wait state on every access
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access & ~pready;
            prdata  <= rdMux;
            pslverr <= access & ~pready & ~mapped;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r   <= 2'h0;
            cmdReg_r <= 6'h3f;
            addr_r   <= 14'h0000;
            wdata_r  <= 64'h0;
            wmask_r  <= 8'h00;
        end else if (wrTake) begin
            if (paddr == `SDRPIN_REG_CTRL) ctrl_r <= pwdata[1:0];
            if (hitCmd && !busy) cmdReg_r <= pwdata[5:0];
            if (paddr == `SDRPIN_REG_ADDR) addr_r <= pwdata[13:0];
            if (paddr == `SDRPIN_REG_WDLO) wdata_r[31:0] <= pwdata;
            if (paddr == `SDRPIN_REG_WDHI) wdata_r[63:32] <= pwdata;
            if (paddr == `SDRPIN_REG_WMASK) wmask_r <= pwdata[7:0];
        end
    end

    // Read strobe and data cross in through two flops together
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_r   <= '0;
            syncB_r   <= '0;
            dqsPrev_r <= 1'b0;
        end else begin
            syncA_r   <= {pins.dq, pins.dqs};
            syncB_r   <= syncA_r;
            dqsPrev_r <= syncB_r[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r        <= sdrpin_pkg::CTL_IDLE;
            launch_r       <= 1'b0;
            rdDone_r       <= 1'b0;
            rdata_r        <= 64'h0;
            beat_r         <= 2'h0;
            ck_r           <= 1'b0;
            dqs_r          <= 1'b0;
            pins.cke       <= 1'b0;
            pins.termination_enable_pin       <= 1'b0;
            pins.csN       <= 1'b1;
            {pins.rasN, pins.casN, pins.weN} <= sdrpin_pkg::CMD_NOP;
            pins.ba        <= 3'h0;
            pins.addr      <= 14'h0000;
            pins.ctlDq     <= '0;
            pins.ctlDm     <= '0;
            pins.ctlDqOeN  <= 1'b1;
            pins.ctlDqsOeN <= 1'b1;
        end else begin
            // Free-running memory clock at half the core rate
            ck_r     <= ~ck_r;
            pins.cke <= ctrl_r[0];                                  // R2
            pins.termination_enable_pin <= ctrl_r[1];
            // A launch while busy is dropped; the set wins over the clear
            rdDone_r <= rdSet | (rdDone_r & ~(wrTake & hitCmd & ~busy));
            if (wrTake && hitCmd && !busy) begin
                launch_r <= 1'b1;
            end
            case (state_r)
                sdrpin_pkg::CTL_IDLE: begin
                    // Pins change as the clock falls, stable across the next rise
                    if (launch_r && ck_r) begin                     // R1
                        launch_r  <= 1'b0;
                        pins.csN  <= 1'b0;
                        {pins.rasN, pins.casN, pins.weN} <= cmdReg_r[2:0];  // R4
                        pins.ba   <= cmdReg_r[5:3];                 // R9
                        pins.addr <= addr_r;
                        state_r   <= sdrpin_pkg::CTL_CMD_LO;
                    end
                end
                sdrpin_pkg::CTL_CMD_LO: begin
                    state_r <= sdrpin_pkg::CTL_CMD_HI;
                end
                sdrpin_pkg::CTL_CMD_HI: begin
                    pins.csN <= 1'b1;                               // R20
                    {pins.rasN, pins.casN, pins.weN} <= sdrpin_pkg::CMD_NOP;
                    beat_r   <= 2'h0;
                    state_r  <= (cmdReg_r[2:0] == sdrpin_pkg::CMD_WR) ? sdrpin_pkg::CTL_WR_SET :
                                (cmdReg_r[2:0] == sdrpin_pkg::CMD_RD) ? sdrpin_pkg::CTL_RD_WAIT :
                                sdrpin_pkg::CTL_IDLE;
                end
                sdrpin_pkg::CTL_WR_SET: begin
                    pins.ctlDq     <= wdata_r[beat_r*DQ_W +: DQ_W];  // R10
                    pins.ctlDm     <= wmask_r[beat_r*LANES +: LANES]; // R15 R16
                    pins.ctlDqOeN  <= 1'b0;
                    pins.ctlDqsOeN <= 1'b0;
                    state_r        <= sdrpin_pkg::CTL_WR_STB;
                end
                sdrpin_pkg::CTL_WR_STB: begin
                    dqs_r   <= ~dqs_r;                              // R11
                    beat_r  <= beat_r + 2'h1;
                    state_r <= (beat_r == 2'(BEATS - 1)) ? sdrpin_pkg::CTL_WR_POST :
                               sdrpin_pkg::CTL_WR_SET;
                end
                sdrpin_pkg::CTL_WR_POST: begin
                    pins.ctlDqOeN  <= 1'b1;
                    pins.ctlDqsOeN <= 1'b1;
                    pins.ctlDm     <= '0;
                    dqs_r          <= 1'b0;
                    state_r        <= sdrpin_pkg::CTL_IDLE;
                end
                sdrpin_pkg::CTL_RD_WAIT: begin
                    // Waits without limit: a read to a closed bank hangs busy
                    if (dqsEdge) begin
                        rdata_r[beat_r*DQ_W +: DQ_W] <= syncB_r[DQ_W+LANES-1:LANES];  // R11
                        beat_r <= beat_r + 2'h1;
                        if (rdSet) begin
                            state_r <= sdrpin_pkg::CTL_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= sdrpin_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    assign pins.ck     = ck_r;
    assign pins.ctlDqs = {LANES{dqs_r}};                            // R12
endmodule : sdrpin_ctrl

// >>> dv/sdrpin_asserts.sv
module sdrpin_asserts #(
    parameter int DQ_W  = 16,
    parameter int LANES = DQ_W / 8
) (
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             ck,
    input wire logic             cke,
    input wire logic             csN,
    input wire logic [DQ_W-1:0]  ctlDq,
    input wire logic             ctlDqOeN,
    input wire logic [LANES-1:0] ctlDqs,
    input wire logic [LANES-1:0] ctlDm,
    input wire logic [DQ_W-1:0]  devDq,
    input wire logic             devDqOeN,
    input wire logic [LANES-1:0] devDqs,
    input wire logic [LANES-1:0] devDqsN,
    input wire logic             devDqsNOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_idle; $past(rst) |-> csN && !cke && ctlDqOeN; endproperty
    a_idle: assert property (p_idle) else $error("not idle");
    property p_hold; $fell(csN) |=> !csN ##1 csN; endproperty
    a_hold: assert property (p_hold) else $error("cmd hold");
    // csN moves only while ck is low, so the rising edge sees a settled level
    property p_edge; $changed(csN) |-> !ck; endproperty
    a_edge: assert property (p_edge) else $error("cs edge");
    property p_own; ctlDqOeN || devDqOeN; endproperty
    a_own: assert property (p_own) else $error("bus clash");
    property p_wctr; !ctlDqOeN && $changed(ctlDqs) |-> $stable(ctlDq) && $stable(ctlDm); endproperty
    a_wctr: assert property (p_wctr) else $error("wr strobe");
    property p_wlen; $fell(ctlDqOeN) |-> !ctlDqOeN [*8] ##1 ctlDqOeN; endproperty
    a_wlen: assert property (p_wlen) else $error("wr length");
    property p_ral; !devDqOeN && !$past(devDqOeN) && $changed(devDq) |-> $changed(devDqs); endproperty
    a_ral: assert property (p_ral) else $error("rd strobe");
    property p_cmp; !devDqsNOeN |-> devDqsN == ~devDqs && !devDqOeN; endproperty
    a_cmp: assert property (p_cmp) else $error("compl strobe");
endmodule : sdrpin_asserts

// >>> dv/sdrpin_tb_top.sv
`include "sdrpin_consts.svh"
module sdrpin_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0, bankOpen;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, powerDown, termActive, busy;
    int          errors = 0, compares = 0, cyc = 0;
    always #5 core_clk = ~core_clk;
    sdrpin_if #(.DQ_W(16)) pins ();
    sdrpin_ctrl #(.DQ_W(16)) sdrpin_ctrl_inst (.core_clk, .rst, .pins, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    sdrpin_device #(.DQ_W(16)) sdrpin_device_inst (.core_clk, .rst, .pins, .bankOpen,
        .powerDown, .termActive, .busy);
    sdrpin_asserts #(.DQ_W(16)) sdrpin_asserts_inst (.core_clk, .rst, .ck(pins.ck),
        .cke(pins.cke), .csN(pins.csN), .ctlDq(pins.ctlDq), .ctlDqOeN(pins.ctlDqOeN),
        .ctlDqs(pins.ctlDqs), .ctlDm(pins.ctlDm), .devDq(pins.devDq),
        .devDqOeN(pins.devDqOeN), .devDqs(pins.devDqs), .devDqsN(pins.devDqsN),
        .devDqsNOeN(pins.devDqsNOeN));
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", 32'(a > 8'h20), 32'(pslverr));
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask : apb
    // No fixed wait: a hung busy flag is cut off by the cycle ceiling
    task automatic cmd(input logic [2:0] b, input sdrpin_pkg::sdrpin_cmd_t c,
                       input logic [13:0] a);
        apb(1, `SDRPIN_REG_ADDR, 32'(a));
        apb(1, `SDRPIN_REG_CMD, 32'({b, c}));
        do apb(0, `SDRPIN_REG_STATUS, '0); while (rd[0] !== 1'b0);
    endtask : cmd
    task automatic wrburst(input logic [31:0] lo, hi, input logic [7:0] m);
        apb(1, `SDRPIN_REG_WDLO, lo);
        apb(1, `SDRPIN_REG_WDHI, hi);
        apb(1, `SDRPIN_REG_WMASK, 32'(m));
        cmd(3'h3, sdrpin_pkg::CMD_WR, 14'h0000);
        chk("done", 32'h0, rd & 32'h3);
    endtask : wrburst
    task automatic rdback(input logic [13:0] a, input logic [31:0] lo, hi);
        cmd(3'h3, sdrpin_pkg::CMD_RD, a);
        chk("done", 32'h2, rd & 32'h3);
        apb(0, `SDRPIN_REG_RDLO, '0);
        chk("rdlo", lo, rd);
        apb(0, `SDRPIN_REG_RDHI, '0);
        chk("rdhi", hi, rd);
    endtask : rdback
    task automatic close_out;
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        apb(1, `SDRPIN_REG_CTRL, 32'h1);
        cmd(3'h0, sdrpin_pkg::CMD_MRS, 14'h0002);
        cmd(3'h1, sdrpin_pkg::CMD_MRS, 14'h0004);
        apb(1, `SDRPIN_REG_CTRL, 32'h3);
        cmd(3'h3, sdrpin_pkg::CMD_ACT, 14'h0001);
        chk("term", 1, termActive);
        chk("open", 8'h08, bankOpen);
        wrburst(32'h2222_1111, 32'h4444_3333, 8'h00);
        rdback(14'h0000, 32'h2222_1111, 32'h4444_3333);
        wrburst(32'h6666_5555, 32'h8888_7777, 8'h86);
        rdback(14'h0400, 32'h6622_1155, 32'h4488_7777);
        chk("open", 8'h00, bankOpen);
        chk("busy", 32'h0, 32'(busy));
        cmd(3'h5, sdrpin_pkg::CMD_ACT, 14'h0002);
        cmd(3'h2, sdrpin_pkg::CMD_ACT, 14'h0002);
        cmd(3'h2, sdrpin_pkg::CMD_PRE, 14'h0000);
        chk("open", 8'h20, bankOpen);
        cmd(3'h6, sdrpin_pkg::CMD_PRE, 14'h0400);
        chk("open", 8'h00, bankOpen);
        cmd(3'h0, sdrpin_pkg::CMD_REF, 14'h0000);
        apb(1, `SDRPIN_REG_CTRL, 32'h0);
        cmd(3'h1, sdrpin_pkg::CMD_ACT, 14'h0001);
        chk("pd", 1, powerDown);
        chk("open", 8'h00, bankOpen);
        apb(0, 8'h24, '0);
        close_out;
    end
endmodule : sdrpin_tb_top
